/* rtl/txws_enc.sv */
// combinational 8B/10B character encoder with running disparity
`timescale 1ns/1ps
module txws_enc (
   input wire logic [7:0] din,
   input wire logic kin,
   input wire logic rd_in,
   output logic [9:0] code,
   output logic rd_out
);
   logic [5:0] s6;
   logic [5:0] o6;
   logic [3:0] s4;
   logic [3:0] o4;
   logic rd1;
   logic a7;
   always_comb begin
      unique case (din[4:0])
         5'h00: s6 = 6'h27;
         5'h01: s6 = 6'h1D;
         5'h02: s6 = 6'h2D;
         5'h03: s6 = 6'h31;
         5'h04: s6 = 6'h35;
         5'h05: s6 = 6'h29;
         5'h06: s6 = 6'h19;
         5'h07: s6 = 6'h38;
         5'h08: s6 = 6'h39;
         5'h09: s6 = 6'h25;
         5'h0A: s6 = 6'h15;
         5'h0B: s6 = 6'h34;
         5'h0C: s6 = 6'h0D;
         5'h0D: s6 = 6'h2C;
         5'h0E: s6 = 6'h1C;
         5'h0F: s6 = 6'h17;
         5'h10: s6 = 6'h1B;
         5'h11: s6 = 6'h23;
         5'h12: s6 = 6'h13;
         5'h13: s6 = 6'h32;
         5'h14: s6 = 6'h0B;
         5'h15: s6 = 6'h2A;
         5'h16: s6 = 6'h1A;
         5'h17: s6 = 6'h3A;
         5'h18: s6 = 6'h33;
         5'h19: s6 = 6'h26;
         5'h1A: s6 = 6'h16;
         5'h1B: s6 = 6'h36;
         5'h1C: s6 = kin ? 6'h0F : 6'h0E;
         5'h1D: s6 = 6'h2E;
         5'h1E: s6 = 6'h1E;
         5'h1F: s6 = 6'h2B;
      endcase
   end
   // balanced D.7 still flips with positive disparity
   assign o6 = (rd_in && ($countones(s6) != 3 || s6 == 6'h38)) ? ~s6 : s6;
   assign rd1 = ($countones(s6) != 3) ? ~rd_in : rd_in;
   // alternate x.7 avoids a run of five
   assign a7 = kin || (!rd1 && (din[4:0] == 5'h11 || din[4:0] == 5'h12 ||
      din[4:0] == 5'h14)) || (rd1 && (din[4:0] == 5'h0B ||
      din[4:0] == 5'h0D || din[4:0] == 5'h0E));
   always_comb begin
      unique case (din[7:5])
         3'h0: s4 = 4'hB;
         3'h1: s4 = kin ? 4'h6 : 4'h9;
         3'h2: s4 = kin ? 4'hA : 4'h5;
         3'h3: s4 = 4'hC;
         3'h4: s4 = 4'hD;
         3'h5: s4 = kin ? 4'h5 : 4'hA;
         3'h6: s4 = kin ? 4'h9 : 4'h6;
         3'h7: s4 = a7 ? 4'h7 : 4'hE;
      endcase
   end
   assign o4 = (rd1 && (kin || $countones(s4) != 2 || din[7:5] == 3'h3))
      ? ~s4 : s4;
   assign rd_out = ($countones(s4) != 2) ? ~rd1 : rd1;
   // bit 0 is a, the first bit out on the line
   assign code = {o4[0], o4[1], o4[2], o4[3],
      o6[0], o6[1], o6[2], o6[3], o6[4], o6[5]};
endmodule

/* rtl/txws_encoder_top.sv */
// transmit character encoder with word sync generation and APB control
`timescale 1ns/1ps
module txws_encoder_top
   import txws_pkg::*;
#(
   parameter int WS_LEN = WS_LEN_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic reference_clock,
   input wire logic host_tx_clock,
   input wire logic [7:0] tx_data,
   input wire logic [1:0] tx_char_control,
   input wire logic special_char_select,
   input wire logic tx_odd_parity_bit,
   output logic [9:0] tx_char,
   output logic tx_char_valid,
   output logic tx_error_flag
);
   if (WS_LEN < 4 || WS_LEN > 16) begin : g_chk
      $error("WS_LEN must lie in 4..16");
   end

   localparam logic [3:0] WS_LAST = 4'(WS_LEN - 1);

   logic [7:0] ctrl;
   logic [3:0] tx_mode_select;
   logic [1:0] parity_check_mode;
   logic [1:0] tx_clock_source_select;
   logic ref_q;
   logic htx_q;
   logic strobe;
   logic [7:0] in_d;
   logic [1:0] in_ct;
   logic in_sc;
   logic in_op;
   logic cap_valid;
   logic rd;
   logic [3:0] ws_cnt;
   logic err_seen;
   logic bypass;
   logic atomic;
   logic intr;
   logic ws_busy;
   logic par_fail;
   logic use_ct;
   txws_kind_t kind;
   txws_act_t act;
   logic [7:0] enc_d;
   logic enc_k;
   logic enc_rd;
   logic [9:0] enc_code;
   logic enc_rdo;
   logic [3:0] next_cnt;
   logic next_err;
   logic [9:0] next_char;
   logic next_rd;
   logic acc;
   logic wr;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_char;
   logic mode_chg;

   assign tx_mode_select = ctrl[CTL_MHI+1:CTL_MLO];
   assign parity_check_mode = ctrl[CTL_PAR+1:CTL_PAR];
   assign tx_clock_source_select = ctrl[CTL_CKS+1:CTL_CKS];

   // upper select: low bypass, mid atomic, high interruptible
   assign bypass = tx_mode_select[3:2] == TRI_L;
   assign atomic = tx_mode_select[3:2] == TRI_M;
   assign intr = tx_mode_select[3];
   assign ws_busy = ws_cnt != 4'h0;

   assign acc = psel && penable;
   assign pready = 1'b1;
   assign wr = acc && pwrite;
   assign hit_ctrl = paddr == OFS_CTRL;
   assign hit_stat = paddr == OFS_STAT;
   assign hit_char = paddr == OFS_CHAR;
   assign pslverr = acc && !(hit_ctrl || hit_stat || hit_char);
   assign mode_chg = wr && hit_ctrl && pstrb[0] &&
      pwdata[CTL_MHI+1:CTL_MLO] != tx_mode_select;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RST;
      end else if (wr && hit_ctrl && pstrb[0]) begin
         ctrl <= pwdata[7:0];
      end
   end

   // read data is set up in the setup phase and held for the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (hit_ctrl) begin
            prdata <= {24'h00_0000, ctrl};
         end else if (hit_stat) begin
            prdata <= {24'h00_0000, tx_error_flag, err_seen, ws_cnt,
               ws_busy, rd};
         end else if (hit_char) begin
            prdata <= {22'h00_0000, tx_char};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // sticky error, write one to clear; a new error wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_seen <= 1'b0;
      end else if (cap_valid && next_err) begin
         err_seen <= 1'b1;
      end else if (wr && hit_stat && pstrb[0] && pwdata[ST_ERRS]) begin
         err_seen <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_q <= 1'b0;
         htx_q <= 1'b0;
      end else begin
         ref_q <= reference_clock;
         htx_q <= host_tx_clock;
      end
   end

   assign strobe = (tx_clock_source_select == TRI_L)
      ? (reference_clock && !ref_q)
      : (host_tx_clock && !htx_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_d <= 8'h00;
         in_ct <= 2'h0;
         in_sc <= 1'b0;
         in_op <= 1'b0;
      end else if (strobe) begin
         in_d <= tx_data;
         in_ct <= tx_char_control;
         in_sc <= special_char_select;
         in_op <= tx_odd_parity_bit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_valid <= 1'b0;
      end else begin
         cap_valid <= strobe;
      end
   end

   assign use_ct = parity_check_mode[1] ||
      (parity_check_mode == TRI_M && bypass);
   assign par_fail = (parity_check_mode != TRI_L) &&
      !(use_ct ? ^{in_d, in_ct, in_op} : ^{in_d, in_op});

   always_comb begin
      kind = TXWS_DATA;
      unique case (tx_mode_select[1:0])
         TRI_L: begin
            if (in_ct == 2'h3) begin
               kind = TXWS_SYNC;
            end else if (in_ct == 2'h1) begin
               kind = in_sc ? TXWS_SPEC : TXWS_FILL;
            end
         end
         TRI_M: begin
            if (in_ct[0] && in_sc) begin
               kind = TXWS_SYNC;
            end else if (in_ct[0]) begin
               kind = in_ct[1] ? TXWS_SPEC : TXWS_FILL;
            end
         end
         default: begin
            unique case (in_ct)
               2'h0: kind = TXWS_DATA;
               2'h1: kind = TXWS_FILL;
               2'h2: kind = TXWS_SPEC;
               2'h3: kind = TXWS_SYNC;
            endcase
         end
      endcase
   end

   // two input tables, each reaching the same special characters
   function automatic logic [7:0] spec_map(input logic tb,
      input logic [7:0] d);
      logic [3:0] idx;
      idx = tb ? d[7:4] : d[3:0];
      if (idx < 4'hC) begin
         spec_map = KCODE[idx];
      end else begin
         spec_map = K28_5_BYTE;
      end
   endfunction

   always_comb begin
      act = TXWS_A_ENC;
      enc_d = in_d;
      enc_k = 1'b0;
      enc_rd = rd;
      next_cnt = ws_cnt;
      next_err = 1'b0;
      if (bypass) begin
         // special select plays no role here; control goes out as the top two bits
         act = par_fail ? TXWS_A_VPOS : TXWS_A_BYP;
         next_err = par_fail;
         next_cnt = 4'h0;
      end else if (atomic && ws_busy) begin
         // input and its parity are ignored mid-sequence
         enc_d = K28_5_BYTE;
         enc_k = 1'b1;
         enc_rd = (ws_cnt == 4'h1 || ws_cnt == 4'h2) ? !rd : rd;
         next_cnt = (ws_cnt == WS_LAST) ? 4'h0 : ws_cnt + 4'h1;
      end else if (par_fail) begin
         act = TXWS_A_VIOL;
         next_err = 1'b1;
         next_cnt = 4'h0;
      end else if (intr && ws_busy && in_ct == 2'h0) begin
         enc_d = K28_5_BYTE;
         enc_k = 1'b1;
         enc_rd = (ws_cnt == 4'h1 || ws_cnt == 4'h2) ? !rd : rd;
         next_cnt = (ws_cnt == WS_LAST) ? 4'h0 : ws_cnt + 4'h1;
      end else begin
         // any other character ends a running sequence
         next_cnt = 4'h0;
         unique case (kind)
            TXWS_DATA: enc_k = 1'b0;
            TXWS_FILL: begin
               enc_d = K28_5_BYTE;
               enc_k = 1'b1;
            end
            TXWS_SPEC: begin
               enc_d = spec_map(tx_mode_select[1:0] != TRI_L, in_d);
               enc_k = 1'b1;
            end
            TXWS_SYNC: begin
               // first character uses the running disparity as is
               enc_d = K28_5_BYTE;
               enc_k = 1'b1;
               next_cnt = 4'h1;
            end
         endcase
      end
   end

   txws_enc u_enc (
      .din(enc_d),
      .kin(enc_k),
      .rd_in(enc_rd),
      .code(enc_code),
      .rd_out(enc_rdo)
   );

   always_comb begin
      next_char = enc_code;
      next_rd = enc_rdo;
      unique case (act)
         TXWS_A_ENC: next_char = enc_code;
         TXWS_A_BYP: begin
            next_char = {in_ct, in_d};
            next_rd = rd;
         end
         TXWS_A_VPOS: begin
            next_char = C07_P;
            next_rd = rd;
         end
         TXWS_A_VIOL: begin
            next_char = rd ? C07_N : C07_P;
            next_rd = rd;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_char <= 10'h000;
         tx_error_flag <= 1'b0;
      end else if (cap_valid) begin
         tx_char <= next_char;
         tx_error_flag <= next_err;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_char_valid <= 1'b0;
      end else begin
         tx_char_valid <= cap_valid;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd <= 1'b0;
      end else if (cap_valid) begin
         rd <= next_rd;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ws_cnt <= 4'h0;
      end else if (mode_chg) begin
         ws_cnt <= 4'h0;
      end else if (cap_valid) begin
         ws_cnt <= next_cnt;
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   byp_pass_a: assert property (cap_valid && bypass && !par_fail
      |=> tx_char == {$past(in_ct), $past(in_d)})
      else $error("bypass character altered");
   byp_viol_a: assert property (cap_valid && bypass && par_fail
      |=> tx_char == C07_P && tx_error_flag)
      else $error("bypass parity failure not replaced");
   enc_viol_a: assert property (cap_valid && !bypass && par_fail &&
      !(atomic && ws_busy) |=> tx_char == ($past(rd) ? C07_N : C07_P))
      else $error("encoded violation has wrong disparity");
   atom_hold_a: assert property (cap_valid && atomic && ws_busy
      |=> (tx_char == K28_5_N || tx_char == K28_5_P) && !tx_error_flag)
      else $error("atomic sync broken by input");
   ws_invert_a: assert property (cap_valid && ws_busy &&
      ws_cnt == 4'h1 && atomic |=> tx_char ==
      ($past(rd) ? K28_5_N : K28_5_P))
      else $error("second sync character not inverted");
   intr_break_a: assert property (cap_valid && intr && ws_busy &&
      in_ct == 2'h2 && !mode_chg |=> ws_cnt == 4'h0)
      else $error("interruptible sync not ended");
   intr_par_a: assert property (cap_valid && intr && ws_busy
      && par_fail && !mode_chg |=> ws_cnt == 4'h0 && tx_error_flag)
      else $error("parity failure did not end sync");
   par_ok_a: assert property (cap_valid && !(atomic && ws_busy) &&
      (parity_check_mode == TRI_L || ^{in_d, in_op})
      && (!parity_check_mode[1] || ^{in_d, in_ct, in_op})
      && (!bypass || parity_check_mode != TRI_M || ^{in_d, in_ct, in_op})
      |=> !tx_error_flag)
      else $error("valid parity flagged");
   mode_clr_a: assert property (mode_chg |=> ws_cnt == 4'h0)
      else $error("sync count survived mode change");
   strobe_lat_a: assert property (strobe |=> cap_valid
      ##1 tx_char_valid)
      else $error("character not delivered two cycles on");
   full_seq_c: cover property (cap_valid && atomic && ws_cnt == WS_LAST);
   intr_brk_c: cover property (cap_valid && intr && ws_busy &&
      in_ct != 2'h0);
   byp_viol_c: cover property (cap_valid && bypass && par_fail);
   spec_c: cover property (cap_valid && !bypass && kind == TXWS_SPEC);
endmodule

/* rtl/txws_pkg.sv */
// constants, types and tables of the transmit character encoder
// Overview of operation
// - upper mode not LOW: encode each input character with 8B/10B coding
// - hand each 10-bit character on, least significant bit sent first
// - two non-overlapping special-code tables map to the same characters
// - two three-level selects choose one of nine transmit modes
// - bypass passes the captured ten bits unchanged to the shifter
// - bypass parity failure sends fixed pattern 1001111000
// - bypass ignores special select; all clocking interprets alike
// - bypass maps data 0..7 to a,b,c,d,e,i,f,g; control to h,j
// - tables ML/HL: data, fill, special, or sync start on 11
// - sync is 16 K28.5; second and third use inverted disparity
// - atomic sync runs all 16 characters, input ignored meanwhile
// - atomic: start seen again at end restarts another sequence
// - atomic: start character parity checked, following 15 are not
// - interruptible: host keeps control 00; anything else ends sync
// - ending an interruptible sequence resets it to its first character
// - interruptible: parity failure ends sync and sends C0.7
// - input register clocks on reference or host clock rising edge
// - parity valid when XOR of selected bits and parity bit is 1
// - parity errors show on the transmit error output
// - parity mode selects data only, data plus control, or off
// - encoded parity failure sends C0.7 of proper disparity
// - tables MM/HM: data, fill, special, select plus bit 0 starts sync
// - tables MH/HH: 00 data, 01 fill, 10 special, 11 sync
package txws_pkg;
   localparam logic [1:0] TRI_L = 2'h0;
   localparam logic [1:0] TRI_M = 2'h1;
   localparam logic [1:0] TRI_H = 2'h2;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STAT = 12'h004;
   localparam logic [11:0] OFS_CHAR = 12'h008;
   localparam int CTL_MLO = 0;
   localparam int CTL_MHI = 2;
   localparam int CTL_PAR = 4;
   localparam int CTL_CKS = 6;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam int ST_ERRS = 6;
   localparam int WS_LEN_DEF = 16;
   localparam logic [9:0] K28_5_N = 10'h17C;
   localparam logic [9:0] K28_5_P = 10'h283;
   localparam logic [9:0] C07_P = 10'h079;
   localparam logic [9:0] C07_N = 10'h386;
   localparam logic [7:0] K28_5_BYTE = 8'hBC;
   localparam logic [7:0] KCODE [12] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C,
      8'h9C, 8'hBC, 8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE};
   typedef enum logic [1:0] {TXWS_DATA, TXWS_FILL, TXWS_SPEC,
      TXWS_SYNC} txws_kind_t;
   typedef enum logic [1:0] {TXWS_A_ENC, TXWS_A_BYP, TXWS_A_VPOS,
      TXWS_A_VIOL} txws_act_t;
endpackage

/* verification/test_txws_encoder_top.sv */
// self-checking bench of the transmit character encoder
`timescale 1ns/1ps
module test_txws_encoder_top;
   import txws_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready, pslverr, reference_clock, host_tx_clock;
   logic special_char_select, tx_odd_parity_bit;
   logic tx_char_valid, tx_error_flag;
   logic [7:0] tx_data;
   logic [1:0] tx_char_control;
   logic [9:0] tx_char;
   int fail_count = 0;
   int checks = 0;
   logic rd = 1'b0;
   logic pinc = 1'b0;
   logic hc = 1'b0;
   logic e;
   logic [31:0] r;
   // {select, control} per lower mode code: data, fill, special, sync
   logic [2:0] dc [3] = '{3'h6, 3'h6, 3'h4};
   logic [2:0] fc [3] = '{3'h1, 3'h1, 3'h5};
   logic [2:0] sc [3] = '{3'h5, 3'h3, 3'h6};
   logic [2:0] yc [3] = '{3'h3, 3'h5, 3'h3};
   always #4 pclk = ~pclk;
   txws_encoder_top #(.WS_LEN(16)) txws_encoder_top_i (.pclk, .presetn,
      .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .reference_clock, .host_tx_clock, .tx_data,
      .tx_char_control, .special_char_select, .tx_odd_parity_bit,
      .tx_char, .tx_char_valid, .tx_error_flag);
   txws_host_model txws_host_model_i (.pclk, .reference_clock,
      .host_tx_clock, .tx_data, .tx_char_control, .special_char_select,
      .tx_odd_parity_bit);
   task automatic tally_and_finish;
      begin
         if (fail_count == 0 && checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task automatic bad(input string m);
      begin
         fail_count++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      begin
         checks++;
         if (g !== x)
            bad($sformatf("reg %h expected %h", g, x));
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (pready !== 1'b1 && n < 50);
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (pready !== 1'b1) begin
            bad("bus timeout");
            tally_and_finish();
         end
      end
   endtask
   task automatic ch(input logic [10:0] c, input logic ok,
      input logic [9:0] x, input logic xe);
      int n;
      logic p;
      begin
         // odd parity over data, and control when included
         p = ~^{c[7:0], c[9:8] & {2{pinc}}};
         txws_host_model_i.send(c, ok ? p : ~p, hc);
         n = 0;
         do begin
            @(negedge pclk);
            n++;
         end while (tx_char_valid !== 1'b1 && n < 30);
         if (tx_char_valid !== 1'b1) begin
            bad("no character");
            tally_and_finish();
         end
         checks++;
         if (tx_char !== x || tx_error_flag !== xe)
            bad($sformatf("char %h %b expected %h %b", tx_char,
               tx_error_flag, x, xe));
      end
   endtask
   function automatic logic [9:0] k(input logic inv);
      begin
         k = (rd ^ inv) ? K28_5_P : K28_5_N;
         rd = ~(rd ^ inv);
      end
   endfunction
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(r, {24'h0, CTRL_RST});
      apb(1'b0, OFS_STAT, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, 12'h00C, 32'h0);
      chk({r[30:0], e}, 32'h1);
      ch(11'h65A, 1'b1, 10'h25A, 1'b0);
      apb(1'b1, OFS_CTRL, 32'h41);
      hc = 1'b1;
      txws_host_model_i.gap = 3;
      ch(11'h1A5, 1'b1, 10'h1A5, 1'b0);
      hc = 1'b0;
      txws_host_model_i.gap = 0;
      apb(1'b1, OFS_CTRL, 32'h04);
      ch(11'h100, 1'b1, k(1'b0), 1'b0);
      apb(1'b1, OFS_CTRL, 32'h10);
      pinc = 1'b1;
      ch(11'h3FF, 1'b0, C07_P, 1'b1);
      ch(11'h3FF, 1'b1, 10'h3FF, 1'b0);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(r & 32'h41, 32'h41);
      apb(1'b1, OFS_STAT, 32'h40);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(r & 32'h40, 32'h0);
      pinc = 1'b0;
      for (int u = 1; u < 3; u++) begin
         for (int l = 0; l < 3; l++) begin
            apb(1'b1, OFS_CTRL, 32'(u * 4 + l));
            ch({dc[l], 8'hB5}, 1'b1, 10'h155, 1'b0);
            ch({fc[l], 8'h00}, 1'b1, k(1'b0), 1'b0);
            ch({sc[l], 8'h5C}, 1'b1, k(1'b0), 1'b0);
            ch({yc[l], 8'h00}, 1'b1, k(1'b0), 1'b0);
            ch(11'h0B5, 1'b1, k(1'b1), 1'b0);
            apb(1'b1, OFS_CTRL, 32'h0);
         end
      end
      apb(1'b1, OFS_CTRL, 32'h14);
      ch(11'h300, 1'b0, rd ? C07_N : C07_P, 1'b1);
      ch(11'h0B5, 1'b1, 10'h155, 1'b0);
      ch(11'h300, 1'b1, k(1'b0), 1'b0);
      for (int i = 1; i < 16; i++)
         ch(11'h1B5, 1'b0, k(i < 3), 1'b0);
      ch(11'h300, 1'b1, k(1'b0), 1'b0);
      ch(11'h0B5, 1'b1, k(1'b1), 1'b0);
      apb(1'b0, OFS_STAT, 32'h0);
      chk({27'h0, r[5:1]}, 32'h5);
      apb(1'b1, OFS_CTRL, 32'h1A);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(r & 32'h3E, 32'h0);
      ch(11'h300, 1'b1, k(1'b0), 1'b0);
      ch(11'h0B5, 1'b1, k(1'b1), 1'b0);
      ch(11'h25C, 1'b1, k(1'b0), 1'b0);
      ch(11'h300, 1'b1, k(1'b0), 1'b0);
      ch(11'h0B5, 1'b1, k(1'b1), 1'b0);
      ch(11'h0B5, 1'b0, rd ? C07_N : C07_P, 1'b1);
      ch(11'h0B5, 1'b1, 10'h155, 1'b0);
      // parity high: control bits count even with encoding on
      apb(1'b1, OFS_CTRL, 32'h2A);
      pinc = 1'b1;
      ch(11'h100, 1'b0, rd ? C07_N : C07_P, 1'b1);
      ch(11'h100, 1'b1, k(1'b0), 1'b0);
      tally_and_finish();
   end
endmodule

/* verification/txws_host_model.sv */
// host model that presents transmit characters on a character clock
`timescale 1ns/1ps
module txws_host_model (
   input wire logic pclk,
   output logic reference_clock,
   output logic host_tx_clock,
   output logic [7:0] tx_data,
   output logic [1:0] tx_char_control,
   output logic special_char_select,
   output logic tx_odd_parity_bit
);
   int gap = 0;
   initial begin
      reference_clock = 1'b0;
      host_tx_clock = 1'b0;
      {special_char_select, tx_char_control, tx_data} = 11'h000;
      tx_odd_parity_bit = 1'b0;
   end
   // one rising edge of the chosen clock per character; clocks idle low
   task automatic send(input logic [10:0] ch, input logic op,
      input logic hc);
      begin
         // idle gap comes first so the caller still sees the answer
         repeat (gap) @(posedge pclk);
         @(posedge pclk);
         {special_char_select, tx_char_control, tx_data} <= ch;
         tx_odd_parity_bit <= op;
         if (hc)
            host_tx_clock <= 1'b1;
         else
            reference_clock <= 1'b1;
         repeat (2) @(posedge pclk);
         host_tx_clock <= 1'b0;
         reference_clock <= 1'b0;
         // released lines show the inverse of the last character
         {special_char_select, tx_char_control, tx_data} <= ~ch;
         tx_odd_parity_bit <= ~op;
      end
   endtask
endmodule
